/* core/sid_divider.sv */
`include "sid_consts.svh"
`default_nettype none

// Overview of operation
// - Divides a signed 32-bit numerator by a signed 16-bit denominator.
// - Quotient is 32 bits; 16-bit remainder reads sign-extended to 32 bits.
// - Results become valid six clock cycles after the division starts.
// - Writing the denominator register, bits 15 to 0, starts a division.
// - Numerator register holds its value for the next division; writing it starts nothing.
// - Reading quotient or remainder during a division stalls the read until done.
// - Quotient and remainder are readable through their result registers after a start.
// - Status bit 1 is set for a zero denominator, cleared otherwise.
// - Most negative numerator divided by minus one gives most negative quotient, zero remainder.
// - Zero flag updates on every denominator write and is read-only.
module sid_divider (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`SID_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire sid_pkg::sid_word_t wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`SID_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output sid_pkg::sid_word_t rdata,
	output logic [1:0] rresp,
	output logic irq
);
	sid_pkg::sid_word_t num_r, num_nxt;
	sid_pkg::sid_half_t den_r, den_nxt;
	sid_pkg::sid_word_t quot_r, quot_nxt;
	sid_pkg::sid_word_t rem_r, rem_nxt;
	logic zeroFlag_r, zeroFlag_nxt;
	logic [`SID_IRQ_MSB:0] istat_r, istat_nxt;
	logic [`SID_IRQ_MSB:0] imask_r, imask_nxt;

	sid_pkg::sid_wr_e wrSt_r, wrSt_nxt;
	logic awHeld_r, awHeld_nxt;
	logic wHeld_r, wHeld_nxt;
	logic [`SID_ADDR_W-1:0] awAddr_r, awAddr_nxt;
	sid_pkg::sid_word_t wData_r, wData_nxt;
	logic [3:0] wStrb_r, wStrb_nxt;
	logic [1:0] bresp_r, bresp_nxt;

	sid_pkg::sid_rd_e rdSt_r, rdSt_nxt;
	logic [`SID_ADDR_W-1:0] rdAddr_r, rdAddr_nxt;
	sid_pkg::sid_word_t rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic awFire, wFire, arFire, doWrite, wrErr;
	logic [`SID_ADDR_W-1:0] wAddr, rdAddrEff;
	sid_pkg::sid_word_t wData, denMerged, maskMerged, rdWord;
	logic [3:0] wStrb;
	logic startDiv, resLoad, calcBusy, calcDone;
	logic needWait, rdErr, rdCapture;
	sid_pkg::sid_word_t calcQuot;
	sid_pkg::sid_half_t calcRem;

	// Byte lanes whose strobe is low keep their old contents.
	function automatic sid_pkg::sid_word_t sidMerge(input sid_pkg::sid_word_t old,
		input sid_pkg::sid_word_t data, input logic [3:0] strb);
		sid_pkg::sid_word_t res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [`SID_ADDR_W-1:0] sidWord(input logic [`SID_ADDR_W-1:0] a);
		return {a[`SID_ADDR_W-1:2], 2'h0};
	endfunction

	function automatic logic sidIsResult(input logic [`SID_ADDR_W-1:0] a);
		return (a == `SID_OFF_QUO) || (a == `SID_OFF_REM);
	endfunction

	sid_div_calc calc (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.start(startDiv),
		.numIn(num_r),
		.denIn(den_nxt),
		.busy(calcBusy),
		.done(calcDone),
		.quot(calcQuot),
		.leftover_value(calcRem)
	);

	// Write channel: address and data are taken in either order and held until both are in.
	assign awready = ce && (wrSt_r == sid_pkg::SID_WR_IDLE) && !awHeld_r;
	assign wready = ce && (wrSt_r == sid_pkg::SID_WR_IDLE) && !wHeld_r;
	assign awFire = awvalid && awready;
	assign wFire = wvalid && wready;
	assign doWrite = ce && (wrSt_r == sid_pkg::SID_WR_IDLE) && (awHeld_r || awFire) && (wHeld_r || wFire);
	assign wAddr = sidWord(awHeld_r ? awAddr_r : awaddr);
	assign wData = wHeld_r ? wData_r : wdata;
	assign wStrb = wHeld_r ? wStrb_r : wstrb;
	assign bvalid = (wrSt_r == sid_pkg::SID_WR_RESP);
	assign bresp = bresp_r;

	always_comb begin
		wrSt_nxt = wrSt_r;
		awHeld_nxt = awHeld_r;
		wHeld_nxt = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bresp_nxt = bresp_r;
		unique case (wrSt_r)
			sid_pkg::SID_WR_IDLE: begin
				if (doWrite) begin
					awHeld_nxt = 1'b0;
					wHeld_nxt = 1'b0;
					bresp_nxt = wrErr ? `SID_RESP_SLVERR : `SID_RESP_OKAY;
					wrSt_nxt = sid_pkg::SID_WR_RESP;
				end else begin
					if (awFire) begin
						awHeld_nxt = 1'b1;
						awAddr_nxt = awaddr;
					end
					if (wFire) begin
						wHeld_nxt = 1'b1;
						wData_nxt = wdata;
						wStrb_nxt = wstrb;
					end
				end
			end
			sid_pkg::SID_WR_RESP: begin
				if (bready) begin
					wrSt_nxt = sid_pkg::SID_WR_IDLE;
				end
			end
			default: wrSt_nxt = sid_pkg::SID_WR_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wrSt_r <= sid_pkg::SID_WR_IDLE;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
			bresp_r <= `SID_RESP_OKAY;
		end else if (ce) begin
			wrSt_r <= wrSt_nxt;
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Register file and operand capture.
	assign denMerged = sidMerge({16'h0000, den_r}, wData, wStrb);
	assign maskMerged = sidMerge({30'h00000000, imask_r}, wData, wStrb);
	assign resLoad = ce && calcDone;

	always_comb begin
		num_nxt = num_r;
		den_nxt = den_r;
		quot_nxt = quot_r;
		rem_nxt = rem_r;
		zeroFlag_nxt = zeroFlag_r;
		imask_nxt = imask_r;
		startDiv = 1'b0;
		wrErr = 1'b0;
		if (doWrite) begin
			unique case (wAddr)
				`SID_OFF_NUM: num_nxt = sidMerge(num_r, wData, wStrb);
				`SID_OFF_DEN: begin
					den_nxt = denMerged[`SID_DEN_MSB:0];
					startDiv = 1'b1;
					zeroFlag_nxt = (den_nxt == '0);
				end
				`SID_OFF_QUO: quot_nxt = sidMerge(quot_r, wData, wStrb);
				`SID_OFF_REM: rem_nxt = sidMerge(rem_r, wData, wStrb);
				`SID_OFF_IMASK: imask_nxt = maskMerged[`SID_IRQ_MSB:0];
				`SID_OFF_STAT, `SID_OFF_ISTAT: wrErr = 1'b0;
				default: wrErr = 1'b1;
			endcase
		end
		// A finishing division outranks a software write to the result registers.
		if (resLoad) begin
			quot_nxt = calcQuot;
			rem_nxt = {{16{calcRem[`SID_DEN_MSB]}}, calcRem};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			num_r <= `SID_RST_NUM;
			den_r <= `SID_RST_DEN;
			quot_r <= `SID_RST_RES;
			rem_r <= `SID_RST_RES;
			zeroFlag_r <= 1'b0;
			imask_r <= `SID_RST_IRQ;
		end else if (ce) begin
			num_r <= num_nxt;
			den_r <= den_nxt;
			quot_r <= quot_nxt;
			rem_r <= rem_nxt;
			zeroFlag_r <= zeroFlag_nxt;
			imask_r <= imask_nxt;
		end
	end

	// Read channel: a result read waits in place while the divider is busy.
	assign arready = ce && (rdSt_r == sid_pkg::SID_RD_IDLE);
	assign arFire = arvalid && arready;
	assign rvalid = (rdSt_r == sid_pkg::SID_RD_RESP);
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign rdAddrEff = (rdSt_r == sid_pkg::SID_RD_IDLE) ? sidWord(araddr) : rdAddr_r;
	assign needWait = sidIsResult(rdAddrEff) && (calcBusy || startDiv);

	always_comb begin
		rdWord = '0;
		rdErr = 1'b0;
		unique case (rdAddrEff)
			`SID_OFF_NUM: rdWord = num_r;
			`SID_OFF_DEN: rdWord = {16'h0000, den_r};
			`SID_OFF_QUO: rdWord = quot_r;
			`SID_OFF_REM: rdWord = rem_r;
			`SID_OFF_STAT: begin
				rdWord[`SID_STAT_ZERO] = zeroFlag_r;
				rdWord[`SID_STAT_IDLE] = !calcBusy;
			end
			`SID_OFF_ISTAT: rdWord[`SID_IRQ_MSB:0] = istat_r;
			`SID_OFF_IMASK: rdWord[`SID_IRQ_MSB:0] = imask_r;
			default: rdErr = 1'b1;
		endcase
	end

	always_comb begin
		rdSt_nxt = rdSt_r;
		rdAddr_nxt = rdAddr_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		rdCapture = 1'b0;
		unique case (rdSt_r)
			sid_pkg::SID_RD_IDLE: begin
				if (arFire) begin
					rdAddr_nxt = sidWord(araddr);
					rdSt_nxt = sid_pkg::SID_RD_WAIT;
					if (!needWait) begin
						rdCapture = 1'b1;
					end
				end
			end
			sid_pkg::SID_RD_WAIT: begin
				if (ce && !needWait) begin
					rdCapture = 1'b1;
				end
			end
			sid_pkg::SID_RD_RESP: begin
				if (rready) begin
					rdSt_nxt = sid_pkg::SID_RD_IDLE;
				end
			end
			default: rdSt_nxt = sid_pkg::SID_RD_IDLE;
		endcase
		if (rdCapture) begin
			rdata_nxt = rdWord;
			rresp_nxt = rdErr ? `SID_RESP_SLVERR : `SID_RESP_OKAY;
			rdSt_nxt = sid_pkg::SID_RD_RESP;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdSt_r <= sid_pkg::SID_RD_IDLE;
			rdAddr_r <= '0;
			rdata_r <= '0;
			rresp_r <= `SID_RESP_OKAY;
		end else if (ce) begin
			rdSt_r <= rdSt_nxt;
			rdAddr_r <= rdAddr_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Interrupt status: a new event in the clearing read's cycle survives the clear.
	always_comb begin
		istat_nxt = istat_r;
		if (rdCapture && (rdAddrEff == `SID_OFF_ISTAT)) begin
			istat_nxt = '0;
		end
		if (resLoad) begin
			istat_nxt[`SID_IRQ_DONE] = 1'b1;
		end
		if (startDiv && zeroFlag_nxt) begin
			istat_nxt[`SID_IRQ_ZERO] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			istat_r <= `SID_RST_IRQ;
		end else if (ce) begin
			istat_r <= istat_nxt;
		end
	end

	assign irq = |(istat_r & imask_r);

	// Checking helpers: operands and age of the running division.
	logic [2:0] chkCnt_r;
	sid_pkg::sid_word_t chkNum_r;
	sid_pkg::sid_half_t chkDen_r;
	sid_pkg::sid_word_t chkDenSext;

	always_ff @(posedge clk) begin
		if (reset) begin
			chkCnt_r <= '0;
			chkNum_r <= '0;
			chkDen_r <= '0;
		end else if (ce) begin
			if (startDiv) begin
				chkCnt_r <= `SID_CNT_FIRST;
				chkNum_r <= num_r;
				chkDen_r <= den_nxt;
			end else if (chkCnt_r != `SID_CNT_SAT) begin
				chkCnt_r <= 3'(chkCnt_r + `SID_CNT_STEP);
			end
		end
	end

	assign chkDenSext = {{16{chkDen_r[`SID_DEN_MSB]}}, chkDen_r};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_start_busy: assert property (ce && startDiv |=> calcBusy && chkCnt_r == `SID_CNT_FIRST)
		else $error("Denominator write did not start a division.");

	a_num_quiet: assert property (ce && doWrite && wAddr == `SID_OFF_NUM && !calcBusy |=> !calcBusy)
		else $error("Numerator write started a division.");

	a_six_cycles: assert property (resLoad |-> chkCnt_r == `SID_DIV_CYCLES)
		else $error("Result loaded at the wrong cycle count.");

	a_read_stall: assert property ($rose(rvalid) && sidIsResult(rdAddr_r) |-> !calcBusy)
		else $error("Result read answered while division running.");

	a_zero_flag: assert property (ce && startDiv |=> zeroFlag_r == (chkDen_r == '0))
		else $error("Zero denominator flag wrong after denominator write.");

	a_rem_sext: assert property (resLoad |=> rem_r[31:16] == {16{rem_r[`SID_DEN_MSB]}})
		else $error("Remainder not sign extended.");

	a_min_neg: assert property (resLoad && chkNum_r == `SID_MIN_NEG && chkDen_r == `SID_MINUS_ONE
		|=> quot_r == `SID_MIN_NEG && rem_r == '0)
		else $error("Overflow case result wrong.");

	a_div_identity: assert property (resLoad && chkDen_r != '0
		|=> 32'(quot_r * chkDenSext + rem_r) == chkNum_r)
		else $error("Quotient times denominator plus remainder differs from numerator.");

	a_rem_sign: assert property (resLoad |=> rem_r == '0 || rem_r[31] == chkNum_r[31])
		else $error("Remainder sign differs from numerator.");

	a_restart: assert property (ce && startDiv && calcBusy |=> calcBusy ##0 chkCnt_r == `SID_CNT_FIRST)
		else $error("Denominator write while busy did not restart.");

	a_gate_freeze: assert property (!ce |=> $stable(quot_r) && $stable(calcBusy) && $stable(chkCnt_r))
		else $error("State changed while clock enable low.");

	a_result_vis: assert property (resLoad |=> quot_r == $past(calcQuot) && !calcBusy)
		else $error("Quotient register not loaded from divider.");
endmodule
`default_nettype wire

/* core/sid_consts.svh */
`ifndef SID_CONSTS_SVH
`define SID_CONSTS_SVH
`define SID_ADDR_W 5
`define SID_OFF_NUM 5'h00
`define SID_OFF_DEN 5'h04
`define SID_OFF_QUO 5'h08
`define SID_OFF_REM 5'h0c
`define SID_OFF_STAT 5'h10
`define SID_OFF_ISTAT 5'h14
`define SID_OFF_IMASK 5'h18
`define SID_RST_NUM 32'h00000000
`define SID_RST_DEN 16'hffff
`define SID_RST_RES 32'h00000000
`define SID_RST_IRQ 2'h0
`define SID_DEN_MSB 15
`define SID_STAT_IDLE 0
`define SID_STAT_ZERO 1
`define SID_IRQ_DONE 0
`define SID_IRQ_ZERO 1
`define SID_IRQ_MSB 1
`define SID_DIV_CYCLES 3'h6
`define SID_CNT_FIRST 3'h1
`define SID_CNT_STEP 3'h1
`define SID_CNT_SAT 3'h7
`define SID_RESP_OKAY 2'h0
`define SID_RESP_SLVERR 2'h2
`define SID_MIN_NEG 32'h80000000
`define SID_MINUS_ONE 16'hffff
`endif

/* core/sid_pkg.sv */
`default_nettype none
package sid_pkg;
	typedef logic [31:0] sid_word_t;
	typedef logic [15:0] sid_half_t;
	typedef enum logic [1:0] {
		SID_WR_IDLE = 2'h1,
		SID_WR_RESP = 2'h2
	} sid_wr_e;
	typedef enum logic [2:0] {
		SID_RD_IDLE = 3'h1,
		SID_RD_WAIT = 3'h2,
		SID_RD_RESP = 3'h4
	} sid_rd_e;
endpackage
`default_nettype wire

/* core/sid_div_calc.sv */
`include "sid_consts.svh"
`default_nettype none
module sid_div_calc (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic start,
	input wire sid_pkg::sid_word_t numIn,
	input wire sid_pkg::sid_half_t denIn,
	output logic busy,
	output logic done,
	output sid_pkg::sid_word_t quot,
	output sid_pkg::sid_half_t leftover_value
);
	sid_pkg::sid_word_t num_r, num_nxt;
	sid_pkg::sid_half_t den_r, den_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;

	// Works on magnitudes so the most negative numerator needs no special path.
	function automatic logic [47:0] sidDivide(input sid_pkg::sid_word_t n, input sid_pkg::sid_half_t d);
		sid_pkg::sid_word_t an, ad, q, r;
		an = n[31] ? 32'(-n) : n;
		ad = d[`SID_DEN_MSB] ? 32'(-{{16{d[`SID_DEN_MSB]}}, d}) : {16'h0000, d};
		q = '0;
		r = '0;
		if (ad != '0) begin
			q = an / ad;
			r = an % ad;
		end
		if (n[31] ^ d[`SID_DEN_MSB]) begin
			q = 32'(-q);
		end
		if (n[31]) begin
			r = 32'(-r);
		end
		return {q, r[15:0]};
	endfunction

	always_comb begin
		num_nxt = num_r;
		den_nxt = den_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		if (start) begin
			num_nxt = numIn;
			den_nxt = denIn;
			cnt_nxt = `SID_CNT_FIRST;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == `SID_DIV_CYCLES) begin
				busy_nxt = 1'b0;
			end else begin
				cnt_nxt = 3'(cnt_r + `SID_CNT_STEP);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			num_r <= `SID_RST_NUM;
			den_r <= `SID_RST_DEN;
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (ce) begin
			num_r <= num_nxt;
			den_r <= den_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign busy = busy_r;
	assign done = busy_r && (cnt_r == `SID_DIV_CYCLES) && !start;
	assign {quot, leftover_value} = sidDivide(num_r, den_r);
endmodule
`default_nettype wire

/* verification/sid_bus_master.sv */
`include "sid_consts.svh"
`default_nettype none
module sid_bus_master (
	input wire logic clk,
	output logic awvalid,
	input wire logic awready,
	output logic [`SID_ADDR_W-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [`SID_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready goes up only after lag edges, so a slow host is exercised as well.
	int lag = 0;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
	end
	// Released lines show the inverse, so a late sample cannot pass by luck.
	task automatic wr(input logic [`SID_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		forever begin
			@(posedge clk);
			n++;
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
				wstrb <= 4'h0;
			end
			if (n >= lag) bready <= 1'b1;
		end
	endtask
	task automatic rd(input logic [`SID_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp,
		output int lat);
		int n;
		n = 0;
		lat = 0;
		arvalid <= 1'b1;
		araddr <= a;
		forever begin
			@(posedge clk);
			n++;
			if (rvalid && rready) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
				lat = -n;
			end
			if (n >= lag) rready <= 1'b1;
		end
		lat += n;
	endtask
endmodule
`default_nettype wire

/* verification/signed_integer_divider_tb_top.sv */
`include "sid_consts.svh"
`default_nettype none
module signed_integer_divider_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
	logic [`SID_ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, mNum, mDen, mQuo, mRem, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, mIst, mMask, resp;
	logic mZero;
	logic [31:0] tn[6] = '{32'h80000000, 32'h80000000, 32'h7fffffff, 32'hffffff9c, 32'h7, 32'h80000000};
	logic [15:0] td[6] = '{16'hffff, 16'h8000, 16'h7fff, 16'h0007, 16'h0, 16'h1};
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int lat;
	always #5 clk = ~clk;
	sid_divider dut (.clk(clk), .reset(reset), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
	sid_bus_master m (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp));
	task stop_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task rdc(input logic [`SID_ADDR_W-1:0] a, input logic [31:0] exp);
		m.rd(a, v, resp, lat);
		chk(v, exp);
		chk(resp, `SID_RESP_OKAY);
	endtask
	function logic [31:0] stat(input logic idle);
		return {30'h0, mZero, idle};
	endfunction
	task start(input logic [31:0] d);
		longint ln, ld;
		m.wr(`SID_OFF_DEN, d, resp);
		mDen = {16'h0, d[15:0]};
		ln = longint'($signed(mNum));
		ld = longint'($signed(d[15:0]));
		mZero = (ld == 0);
		mIst |= {mZero, 1'b1};
		mQuo = mZero ? 32'h0 : 32'(ln / ld);
		mRem = mZero ? 32'h0 : 32'(ln % ld);
	endtask
	task divide(input logic [31:0] n, input logic [31:0] d);
		m.wr(`SID_OFF_NUM, n, resp);
		mNum = n;
		start(d);
	endtask
	// Wait a whole edge so the level output has settled and the next request still starts on an edge.
	task irqchk();
		@(posedge clk);
		chk({31'h0, irq}, {31'h0, |(mIst & mMask)});
	endtask
	initial begin
		void'($urandom(91054));
		{mNum, mQuo, mRem, mIst, mMask, mZero} = '0;
		mDen = 32'h0000ffff;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rdc(`SID_OFF_DEN, mDen);
		rdc(`SID_OFF_STAT, stat(1'b1));
		rdc(`SID_OFF_NUM, 32'h0);
		rdc(`SID_OFF_REM, 32'h0);
		divide(32'hfffffff9, 32'h2);
		rdc(`SID_OFF_STAT, stat(1'b0));
		m.rd(`SID_OFF_QUO, v, resp, lat);
		chk(v, mQuo);
		chk(32'(lat > 1), 32'h1);
		rdc(`SID_OFF_REM, mRem);
		rdc(`SID_OFF_STAT, stat(1'b1));
		for (int i = 0; i < 26; i++) begin
			m.lag = $urandom_range(0, 3);
			mMask = 2'($urandom);
			m.wr(`SID_OFF_IMASK, {30'h0, mMask}, resp);
			if (i < 6) divide(tn[i], {16'h0, td[i]});
			else divide($urandom, $urandom);
			rdc(`SID_OFF_QUO, mQuo);
			rdc(`SID_OFF_REM, mRem);
			rdc(`SID_OFF_STAT, stat(1'b1));
			rdc(`SID_OFF_DEN, mDen);
			irqchk();
			rdc(`SID_OFF_ISTAT, {30'h0, mIst});
			mIst = 2'h0;
			irqchk();
		end
		m.lag = 0;
		divide(32'h00000064, 32'h5);
		start(32'h3);
		rdc(`SID_OFF_QUO, mQuo);
		m.wr(`SID_OFF_NUM, 32'h12345678, resp);
		rdc(`SID_OFF_STAT, stat(1'b1));
		rdc(`SID_OFF_QUO, mQuo);
		rdc(`SID_OFF_NUM, 32'h12345678);
		mNum = 32'h12345678;
		m.wr(`SID_OFF_STAT, 32'hffffffff, resp);
		chk(resp, `SID_RESP_OKAY);
		rdc(`SID_OFF_STAT, stat(1'b1));
		m.wr(5'h1c, 32'h1, resp);
		chk(resp, `SID_RESP_SLVERR);
		m.rd(5'h1c, v, resp, lat);
		chk(resp, `SID_RESP_SLVERR);
		m.wr(`SID_OFF_QUO, 32'h1234abcd, resp);
		rdc(`SID_OFF_QUO, 32'h1234abcd);
		start(32'h9);
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		rdc(`SID_OFF_STAT, stat(1'b0));
		rdc(`SID_OFF_QUO, mQuo);
		stop_test();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
endmodule
`default_nettype wire
